// ==== tcp_pkg.sv ====
`default_nettype none

package tcp_pkg;

  localparam int          TCP_NUM_TIMERS  = 2;
  localparam int          TCP_ADDR_W      = 6;
  localparam int          TCP_TICK_DIV    = 4;

  // Byte offsets of the per-timer block and the shared interrupt registers; timer B sits one stride above timer A
  localparam logic [5:0]  TCP_OFS_CSR     = 6'h00;
  localparam logic [5:0]  TCP_OFS_CR1     = 6'h04;
  localparam logic [5:0]  TCP_OFS_CMPH    = 6'h08;
  localparam logic [5:0]  TCP_OFS_CMPL    = 6'h0C;
  localparam logic [5:0]  TCP_OFS_TSTRIDE = 6'h10;
  localparam logic [5:0]  TCP_OFS_IRQ_STS = 6'h20;
  localparam logic [5:0]  TCP_OFS_IRQ_CLR = 6'h24;
  localparam logic [5:0]  TCP_OFS_IRQ_EN  = 6'h28;

  // Control/status register fields
  localparam int          TCP_BIT_FLAG    = 7;
  localparam int          TCP_BIT_DIS     = 6;
  localparam int          TCP_BIT_SKIP    = 1;
  localparam int          TCP_BIT_OUT     = 0;
  // First control register fields
  localparam int          TCP_BIT_CIE     = 6;
  localparam int          TCP_BIT_PWM     = 4;
  localparam int          TCP_BIT_LVLB    = 1;
  localparam int          TCP_BIT_LVLA    = 0;

  localparam logic [15:0] TCP_CMP_SKIP    = 16'hFFFC;
  localparam logic [15:0] TCP_CMP_RST     = 16'hFFFF;
  localparam logic [15:0] TCP_CNT_RST     = 16'h0000;
  localparam logic [15:0] TCP_CNT_TOP     = 16'hFFFF;
  localparam logic [15:0] TCP_CNT_STEP    = 16'h0001;
  localparam logic        TCP_DIS_RST     = 1'b0;
  localparam logic        TCP_CIE_RST     = 1'b0;
  localparam logic        TCP_OUT_RST     = 1'b0;

  typedef enum logic {TCP_BUS_IDLE, TCP_BUS_ANSWER} tcp_bus_t;

endpackage : tcp_pkg

`default_nettype wire

// ==== tcp_tick.sv ====
`default_nettype none

module tcp_tick import tcp_pkg::*; #(
  parameter int DIV = TCP_TICK_DIV
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);

  localparam int          CW    = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (count == LAST);
      count    <= (count == LAST) ? '0 : CW'(count + 1'b1);
    end
  end

endmodule : tcp_tick

`default_nettype wire

// ==== tcp_top.sv ====
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`default_nettype none

module tcp_top import tcp_pkg::*; #(
  parameter int TICK_DIV = TCP_TICK_DIV
) (
  input  wire logic                  MCLK_IN,
  input  wire logic                  NRST_IN,
  input  wire logic [TCP_ADDR_W-1:0] AVS_ADDRESS_IN,
  input  wire logic                  AVS_READ_IN,
  input  wire logic                  AVS_WRITE_IN,
  input  wire logic [31:0]           AVS_WRITEDATA_IN,
  input  wire logic [3:0]            AVS_BYTEENABLE_IN,
  output logic      [31:0]           AVS_READDATA_OUT,
  output logic                       AVS_WAITREQUEST_OUT,
  output logic                       IRQ_OUT,
  output logic                       PWM_A_OUT,
  output logic                       PWM_B_OUT
);

  localparam int N = TCP_NUM_TIMERS;

  function automatic logic tcp_hit(input logic [5:0] a, input logic [5:0] ofs, input int t);
    logic [5:0] base;
    base = (t == 1) ? TCP_OFS_TSTRIDE : 6'h00;
    return a == 6'(ofs + base);
  endfunction : tcp_hit

  tcp_bus_t      bus_state;
  logic          tick;
  logic          wr_go;
  logic [7:0]    wdata;
  logic [31:0]   next_rdata;

  logic          dis      [N];
  logic          stuck    [N];
  logic          flag     [N];
  logic          cie      [N];
  logic          pwm_mode [N];
  logic          lvl_a    [N];
  logic          lvl_b    [N];
  logic          skip_pend[N];
  logic          skip_act [N];
  logic          pwm      [N];
  logic [15:0]   cnt      [N];
  logic [15:0]   cmp      [N];

  logic [N-1:0]  cmp_evt;
  logic [N-1:0]  wrap;
  logic [N-1:0]  tim_req;
  logic [N-1:0]  wr_csr;
  logic [N-1:0]  wr_cr1;
  logic [N-1:0]  wr_hi;
  logic [N-1:0]  wr_lo;
  logic [N-1:0]  irq_sts;
  logic [N-1:0]  irq_en;

  tcp_tick #(.DIV(TICK_DIV)) u_tick (
    .clk_in   (MCLK_IN),
    .rst_n_in (NRST_IN),
    .tick_out (tick)
  );

  // Every access gets exactly one wait cycle; read data is captured on the first
  assign AVS_WAITREQUEST_OUT = (bus_state == TCP_BUS_IDLE) & (AVS_READ_IN | AVS_WRITE_IN);
  assign wr_go = AVS_WRITE_IN & (bus_state == TCP_BUS_ANSWER) & AVS_BYTEENABLE_IN[0];
  assign wdata = AVS_WRITEDATA_IN[7:0];

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      bus_state <= TCP_BUS_IDLE;
    end else begin
      unique case (bus_state)
        TCP_BUS_IDLE: begin
          if (AVS_READ_IN | AVS_WRITE_IN) begin
            bus_state <= TCP_BUS_ANSWER;
          end
        end
        TCP_BUS_ANSWER: begin
          bus_state <= TCP_BUS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int t = 0; t < N; t++) begin
      if (tcp_hit(AVS_ADDRESS_IN, TCP_OFS_CSR, t)) begin
        next_rdata[TCP_BIT_FLAG] = flag[t];
        next_rdata[TCP_BIT_DIS]  = dis[t];
        next_rdata[TCP_BIT_SKIP] = skip_act[t];
        next_rdata[TCP_BIT_OUT]  = pwm[t];
      end
      if (tcp_hit(AVS_ADDRESS_IN, TCP_OFS_CR1, t)) begin
        next_rdata[TCP_BIT_CIE]  = cie[t];
        next_rdata[TCP_BIT_PWM]  = pwm_mode[t];
        next_rdata[TCP_BIT_LVLB] = lvl_b[t];
        next_rdata[TCP_BIT_LVLA] = lvl_a[t];
      end
      if (tcp_hit(AVS_ADDRESS_IN, TCP_OFS_CMPH, t)) begin
        next_rdata[7:0] = cmp[t][15:8];
      end
      if (tcp_hit(AVS_ADDRESS_IN, TCP_OFS_CMPL, t)) begin
        next_rdata[7:0] = cmp[t][7:0];
      end
    end
    if (AVS_ADDRESS_IN == TCP_OFS_IRQ_STS) begin
      next_rdata[N-1:0] = irq_sts;
    end
    if (AVS_ADDRESS_IN == TCP_OFS_IRQ_EN) begin
      next_rdata[N-1:0] = irq_en;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (AVS_READ_IN && bus_state == TCP_BUS_IDLE) begin
      AVS_READDATA_OUT <= next_rdata;
    end
  end

  for (genvar t = 0; t < N; t++) begin : g_tim
    assign wr_csr[t]  = wr_go & tcp_hit(AVS_ADDRESS_IN, TCP_OFS_CSR, t);
    assign wr_cr1[t]  = wr_go & tcp_hit(AVS_ADDRESS_IN, TCP_OFS_CR1, t);
    assign wr_hi[t]   = wr_go & tcp_hit(AVS_ADDRESS_IN, TCP_OFS_CMPH, t);
    assign wr_lo[t]   = wr_go & tcp_hit(AVS_ADDRESS_IN, TCP_OFS_CMPL, t);
    assign cmp_evt[t] = tick & ~dis[t] & (cnt[t] == cmp[t]);
    assign wrap[t]    = tick & ~dis[t] & (cnt[t] == TCP_CNT_TOP);
    assign tim_req[t] = flag[t] & cie[t];

    always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN) begin
        cnt[t] <= TCP_CNT_RST;
      end else if (tick && !dis[t]) begin
        cnt[t] <= 16'(cnt[t] + TCP_CNT_STEP);
      end
    end

    always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN) begin
        dis[t]   <= TCP_DIS_RST;
        stuck[t] <= 1'b0;
      end else if (wr_csr[t]) begin
        dis[t] <= wdata[TCP_BIT_DIS];
        // Disabling on the very tick of a match locks the flag until re-enable
        if (wdata[TCP_BIT_DIS] && cmp_evt[t]) begin
          stuck[t] <= 1'b1;
        end else if (!wdata[TCP_BIT_DIS]) begin
          stuck[t] <= 1'b0;
        end
      end
    end

    // A new match beats a software clear in the same cycle
    always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN) begin
        flag[t] <= 1'b0;
      end else if (cmp_evt[t]) begin
        flag[t] <= 1'b1;
      end else if (wr_csr[t] && wdata[TCP_BIT_FLAG] && !stuck[t]) begin
        flag[t] <= 1'b0;
      end
    end

    always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN) begin
        cie[t]      <= TCP_CIE_RST;
        pwm_mode[t] <= 1'b0;
        lvl_a[t]    <= 1'b0;
        lvl_b[t]    <= 1'b0;
      end else if (wr_cr1[t]) begin
        cie[t]      <= wdata[TCP_BIT_CIE];
        pwm_mode[t] <= wdata[TCP_BIT_PWM];
        lvl_a[t]    <= wdata[TCP_BIT_LVLA];
        lvl_b[t]    <= wdata[TCP_BIT_LVLB];
      end
    end

    always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN) begin
        cmp[t] <= TCP_CMP_RST;
      end else if (wr_hi[t]) begin
        cmp[t][15:8] <= wdata;
      end else if (wr_lo[t]) begin
        cmp[t][7:0] <= wdata;
      end
    end

    // The pending skip is consumed at the next period start
    always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN) begin
        skip_pend[t] <= 1'b0;
        skip_act[t]  <= 1'b0;
      end else begin
        if (wrap[t] && pwm_mode[t]) begin
          skip_act[t] <= skip_pend[t];
        end
        if (wr_lo[t] && pwm_mode[t] && {cmp[t][15:8], wdata} == TCP_CMP_SKIP) begin
          skip_pend[t] <= 1'b1;
        end else if (wrap[t] && pwm_mode[t]) begin
          skip_pend[t] <= 1'b0;
        end
      end
    end

    always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN) begin
        pwm[t] <= TCP_OUT_RST;
      end else if (wrap[t] && pwm_mode[t]) begin
        pwm[t] <= skip_pend[t] ? lvl_b[t] : lvl_a[t];
      end else if (cmp_evt[t]) begin
        pwm[t] <= pwm_mode[t] ? lvl_b[t] : lvl_a[t];
      end
    end
  end

  // Status follows the level request, so a locked flag keeps it set through each clear
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      irq_sts <= '0;
    end else if (wr_go && AVS_ADDRESS_IN == TCP_OFS_IRQ_CLR) begin
      irq_sts <= (irq_sts & ~wdata[N-1:0]) | tim_req;
    end else begin
      irq_sts <= irq_sts | tim_req;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      irq_en <= '0;
    end else if (wr_go && AVS_ADDRESS_IN == TCP_OFS_IRQ_EN) begin
      irq_en <= wdata[N-1:0];
    end
  end

  assign IRQ_OUT   = |(irq_sts & irq_en);
  assign PWM_A_OUT = pwm[0];
  assign PWM_B_OUT = pwm[1];

  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);

  property p_skip_arm;
    wr_lo[0] && pwm_mode[0] && {cmp[0][15:8], wdata} == TCP_CMP_SKIP |=> skip_pend[0];
  endproperty
  a_skip_arm: assert property (p_skip_arm) else $error("skip not armed");

  property p_skip_level;
    $rose(skip_act[0]) |-> pwm[0] == $past(lvl_b[0]) && !skip_pend[0];
  endproperty
  a_skip_level: assert property (p_skip_level) else $error("skipped period level");

  property p_lock_set;
    cmp_evt[1] && wr_csr[1] && wdata[TCP_BIT_DIS] |=> stuck[1] && flag[1] && dis[1];
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("flag not locked");

  property p_lock_hold;
    stuck[1] && flag[1] && wr_csr[1] && wdata[TCP_BIT_FLAG] |=> flag[1];
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked flag cleared");

  property p_req_repeat;
    flag[0] && cie[0] && irq_en[0] |=> irq_sts[0] ##1 IRQ_OUT;
  endproperty
  a_req_repeat: assert property (p_req_repeat) else $error("request dropped");

  property p_dis_hold;
    dis[0] |-> !cmp_evt[0] ##1 cnt[0] == $past(cnt[0]);
  endproperty
  a_dis_hold: assert property (p_dis_hold) else $error("counter ran");

  property p_dis_write;
    wr_csr[1] |=> dis[1] == $past(wdata[TCP_BIT_DIS]);
  endproperty
  a_dis_write: assert property (p_dis_write) else $error("disable bit");

  property p_cie_write;
    wr_cr1[0] |=> cie[0] == $past(wdata[TCP_BIT_CIE]) && tim_req[0] == (flag[0] && cie[0]);
  endproperty
  a_cie_write: assert property (p_cie_write) else $error("interrupt enable bit");

  property p_match_flag;
    cmp_evt[0] |=> flag[0] ##1 (flag[0] || !stuck[0]);
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("flag not set");

  property p_wait_one;
    AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest stuck");

  property p_cv_lock;
    stuck[1] ##1 !stuck[1];
  endproperty
  c_cv_lock: cover property (p_cv_lock);

  property p_cv_skip;
    skip_act[0] ##1 !skip_act[0];
  endproperty
  c_cv_skip: cover property (p_cv_skip);

  property p_cv_irq;
    !IRQ_OUT ##1 IRQ_OUT;
  endproperty
  c_cv_irq: cover property (p_cv_irq);

endmodule : tcp_top

`default_nettype wire

// ==== tcp_top_tb.sv ====
`default_nettype none

module tcp_top_tb import tcp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [5:0] B = TCP_OFS_TSTRIDE;

  logic        clk   = 1'b0;
  logic        nrst  = 1'b0;
  logic [5:0]  adr   = 6'h00;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [31:0] wd    = 32'h0;
  logic [3:0]  be    = 4'hF;
  logic [31:0] rdat;
  logic        wreq;
  logic        irq;
  logic        pwm_a;
  logic        pwm_b;
  logic [31:0] q;
  logic        found;
  int          failures  = 0;
  int          cmp_count = 0;
  int          cyc       = 0;

  always #5 clk = ~clk;

  // Fastest tick keeps one full counter period inside the run budget
  tcp_top #(.TICK_DIV(1)) uut (
    .MCLK_IN            (clk),
    .NRST_IN            (nrst),
    .AVS_ADDRESS_IN     (adr),
    .AVS_READ_IN        (rd),
    .AVS_WRITE_IN       (wr),
    .AVS_WRITEDATA_IN   (wd),
    .AVS_BYTEENABLE_IN  (be),
    .AVS_READDATA_OUT   (rdat),
    .AVS_WAITREQUEST_OUT(wreq),
    .IRQ_OUT            (irq),
    .PWM_A_OUT          (pwm_a),
    .PWM_B_OUT          (pwm_b)
  );

  task automatic end_of_test;
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Waitrequest and read data are taken at the edge that ends the wait;
  // only the bench timeout limits how long the slave may stall
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] e = 4'hF);
    adr <= a;
    wr  <= w;
    rd  <= ~w;
    wd  <= {24'h0, d};
    be  <= e;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    check(q, exp);
  endtask : rd_chk

  task automatic chk_irq(input logic exp);
    @(negedge clk);
    check(32'(irq), 32'(exp));
    @(posedge clk);
  endtask : chk_irq

  task automatic do_reset;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  task automatic test_regs;
    do_reset();
    rd_chk(TCP_OFS_CSR, 32'h00);
    rd_chk(TCP_OFS_CR1, 32'h00);
    bus(1'b1, TCP_OFS_CR1, 8'h53, 4'h0);
    rd_chk(TCP_OFS_CR1, 32'h00);
    bus(1'b1, TCP_OFS_CR1, 8'h53);
    rd_chk(TCP_OFS_CR1, 32'h53);
    bus(1'b1, TCP_OFS_CR1, 8'h00);
    rd_chk(6'h30, 32'h00);
    rd_chk(TCP_OFS_IRQ_CLR, 32'h00);
    bus(1'b1, TCP_OFS_IRQ_EN, 8'h03);
    rd_chk(TCP_OFS_IRQ_EN, 32'h03);
    bus(1'b1, TCP_OFS_IRQ_EN, 8'h00);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_flag;
    bus(1'b1, TCP_OFS_CSR, 8'h40);
    bus(1'b1, TCP_OFS_CMPH, 8'h00);
    bus(1'b1, TCP_OFS_CMPL, 8'h80);
    bus(1'b1, TCP_OFS_CR1, 8'h40);
    repeat (300) @(posedge clk);
    rd_chk(TCP_OFS_CSR, 32'h40);
    bus(1'b1, TCP_OFS_CSR, 8'h00);
    repeat (200) @(posedge clk);
    rd_chk(TCP_OFS_CSR, 32'h80);
    chk_irq(1'b0);
    bus(1'b1, TCP_OFS_IRQ_EN, 8'h01);
    chk_irq(1'b1);
    bus(1'b1, TCP_OFS_CR1, 8'h00);
    bus(1'b1, TCP_OFS_IRQ_CLR, 8'h01);
    chk_irq(1'b0);
    bus(1'b1, TCP_OFS_CSR, 8'h80);
    rd_chk(TCP_OFS_CSR, 32'h00);
    bus(1'b1, TCP_OFS_IRQ_EN, 8'h00);
    $display("test_flag done");
  endtask : test_flag

  // The disable write is slid one cycle at a time until it lands on the match
  task automatic test_lock;
    found = 1'b0;
    for (int d = 30; d < 100 && !found; d++) begin
      do_reset();
      bus(1'b1, B + TCP_OFS_CMPH, 8'h00);
      bus(1'b1, B + TCP_OFS_CMPL, 8'h60);
      bus(1'b1, B + TCP_OFS_CR1, 8'h40);
      bus(1'b1, TCP_OFS_IRQ_EN, 8'h02);
      repeat (d) @(posedge clk);
      bus(1'b1, B + TCP_OFS_CSR, 8'h40);
      bus(1'b1, B + TCP_OFS_CSR, 8'hC0);
      bus(1'b0, B + TCP_OFS_CSR, 8'h00);
      found = q[7];
    end
    check(32'(found), 32'h1);
    chk_irq(1'b1);
    bus(1'b1, TCP_OFS_IRQ_CLR, 8'h02);
    rd_chk(TCP_OFS_IRQ_STS, 32'h02);
    chk_irq(1'b1);
    bus(1'b1, TCP_OFS_IRQ_EN, 8'h00);
    chk_irq(1'b0);
    bus(1'b1, B + TCP_OFS_CR1, 8'h00);
    bus(1'b1, B + TCP_OFS_CSR, 8'h00);
    bus(1'b1, B + TCP_OFS_CSR, 8'h80);
    rd_chk(B + TCP_OFS_CSR, 32'h00);
    bus(1'b1, TCP_OFS_IRQ_CLR, 8'h02);
    bus(1'b1, TCP_OFS_IRQ_EN, 8'h02);
    bus(1'b1, B + TCP_OFS_CR1, 8'h40);
    chk_irq(1'b0);
    $display("test_lock done");
  endtask : test_lock

  task automatic test_skip;
    do_reset();
    bus(1'b1, TCP_OFS_CR1, 8'h11);
    bus(1'b1, TCP_OFS_CMPH, 8'hFF);
    bus(1'b1, TCP_OFS_CMPL, 8'hFC);
    bus(1'b1, B + TCP_OFS_CR1, 8'h12);
    bus(1'b1, B + TCP_OFS_CMPH, 8'hFF);
    bus(1'b1, B + TCP_OFS_CMPL, 8'hFC);
    // Lands just past the first wrap, one full period after reset
    repeat (65560) @(posedge clk);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      check(32'({pwm_a, pwm_b}), 32'h1);
      repeat (500) @(posedge clk);
    end
    rd_chk(TCP_OFS_CSR, 32'h82);
    rd_chk(B + TCP_OFS_CSR, 32'h83);
    $display("test_skip done");
  endtask : test_skip

  initial begin
    test_regs();
    test_flag();
    test_lock();
    test_skip();
    end_of_test();
  end
endmodule : tcp_top_tb

`default_nettype wire
